// File: include/ccu_map.svh
// register indexes, reset values and divider counts of the compare unit
`ifndef CCU_MAP_SVH
`define CCU_MAP_SVH
// byte address of a register is four times its index
`define IDX_COMSET_LO 10'h0A1
`define IDX_COMSET_HI 10'h0A2
`define IDX_COMCLR_LO 10'h0A3
`define IDX_COMCLR_HI 10'h0A4
`define IDX_SET_MASK 10'h0A5
`define IDX_CLR_MASK 10'h0A6
`define IDX_FLAGS 10'h0B0
`define IDX_CC_BASE 10'h0C0
`define IDX_CC_FUNC 10'h0C1
`define IDX_CTRL 10'h0C8
`define IDX_CC_EDGE 10'h0C9
`define IDX_CRC_LO 10'h0CA
`define IDX_CRC_HI 10'h0CB
`define IDX_GT_LO 10'h0CC
`define IDX_GT_HI 10'h0CD
`define IDX_CC_MODE 10'h0D1
`define IDX_CM_BASE 10'h0D2
`define IDX_CM_GROUP 10'h010
`define IDX_CT_RELOAD_LO 10'h0DE
`define IDX_CT_RELOAD_HI 10'h0DF
`define IDX_CT_PRE 10'h0E0
`define IDX_CM_LEVEL 10'h0F1
`define IDX_CM_EN 10'h0F6
`define IDX_CM_SEL 10'h0F7
`define IDX_PORT5 10'h0F8
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define RESET_PORT 8'hFF
`define COUNT_TOP 16'hFFFF
`define GT_BASE_DIV 4'hB
`define GT_MIN_GAP 8
`endif

// File: include/ccu_pkg.sv
// types of the compare unit
package ccu_pkg;
    typedef enum logic [1:0] {CC_OFF, CC_CAP_PIN, CC_COMPARE, CC_CAP_SW}
        cc_func_t;
    typedef enum logic [1:0] {RL_OFF, RL_SPARE, RL_OVF, RL_PIN}
        reload_mode_t;
    typedef struct packed {
        logic spare;
        logic mode2_en;
        logic ct_run;
        reload_mode_t reload_mode;
        logic gt_run;
        logic [1:0] gt_presc;
    } ctrl_t;
    typedef struct packed {
        logic [7:0] cm_match;
        logic [3:0] cc_event;
        logic clear_match_flag;
        logic set_match_flag;
        logic compare_timer_overflow_flag;
        logic external_reload_flag;
        logic general_timer_overflow_flag;
    } flags_t;
endpackage : ccu_pkg

// File: src/compare_capture_reload_unit.sv
// compare, capture and reload array with general and compare timers
`timescale 1ns/10ps
`include "ccu_map.svh"
// Behaviour
// - compare each 16-bit value with its timer; on equality act on pins, and flag if on the general timer
// - mode 0 output rises on match
// - mode 0 output falls on overflow of its timer
// - mode 1 output takes the software preselected level on match
// - mode 1 output ignores timer overflow
// - set compare match drives high port pins selected by set mask
// - clear compare match drives low port pins selected by clear mask
// - software writes and reads the port pins directly
// - compare-timer channels use shadows loaded at every overflow
// - capture mode 0 copies the timer on a capture pin transition
// - capture mode 1 copies the timer when low byte is written
// - reload value is low and high reload bytes joined
// - reload mode 0 reloads the timer at overflow
// - reload mode 1 reloads on falling reload pin edge, sets flag
// - overflow and reload flags share one timer request
// - general compare matches on general timer share one request
// - set compare match raises its own request
// - clear compare match raises its own request
// - capture pin interrupts trigger on a selectable edge
// - each general compare channel picks either timer
// - general timer ticks at most every twelfth clock, 2-bit prescaler
// - compare timer has 8-bit prescaler, reload, at most half clock
module compare_capture_reload_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] cc_pin_in,
    output logic [3:0] cc_out,
    output logic [7:0] cm_out,
    input wire logic [7:0] port5_in,
    output logic [7:0] port5_out,
    input wire logic external_reload_pin,
    output logic irq_timer2,
    output logic irq_compare,
    output logic irq_set_match,
    output logic irq_clear_match,
    output logic irq_compare_timer,
    output logic [3:0] irq_cc
);
    logic [9:0] widx;
    logic acc_w;
    ccu_pkg::ctrl_t ctrl;
    ccu_pkg::flags_t flags, flag_set;
    logic [7:0] cc_func, cc_mode, cm_en, cm_sel, cm_level, ct_pre;
    logic [3:0] cc_edge, cc_prev, cc_hit;
    logic [15:0] gt, gt_next, ct, ct_next, ct_reload, comset, comclr, crc;
    logic [15:0] cc_val [4];
    logic [15:0] cm_val [8];
    logic [15:0] cm_shadow [8];
    logic [7:0] set_mask, clear_mask, fifth_port_register, cm_hit_gt;
    logic [3:0] gt_div;
    logic [1:0] gt_pre;
    logic [8:0] ct_div;
    logic base_tick, gt_tick, gt_ovf, ct_tick, ct_ovf, ext_prev;
    logic pin_reload, set_hit, clr_hit;
    logic [31:0] rd_data;
    logic rd_ok;

    assign widx = paddr[11:2];
    assign acc_w = psel && penable && pwrite;

    function automatic logic wr_at(input logic [9:0] i);
        wr_at = acc_w && widx == i;
    endfunction : wr_at

    function automatic logic [9:0] cm_lo(input int i);
        cm_lo = 10'(`IDX_CM_BASE + `IDX_CM_GROUP * (i / 3) + 2 * (i % 3));
    endfunction : cm_lo

    function automatic logic [9:0] cc_lo(input int i);
        cc_lo = (i == 0) ? `IDX_CRC_LO : 10'(`IDX_CC_BASE + 2 * i);
    endfunction : cc_lo

    // timer state comes in as arguments so continuous assigns see each tick
    function automatic logic gt_hit(input logic t, input logic [15:0] n,
        input logic [15:0] v);
        gt_hit = t && n == v;
    endfunction : gt_hit

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= ccu_pkg::ctrl_t'(`RESET_BYTE);
            cc_func <= `RESET_BYTE;
            cc_mode <= `RESET_BYTE;
            cc_edge <= 4'h0;
            cm_en <= `RESET_BYTE;
            cm_sel <= `RESET_BYTE;
            cm_level <= `RESET_BYTE;
            ct_pre <= `RESET_BYTE;
            set_mask <= `RESET_BYTE;
            clear_mask <= `RESET_BYTE;
        end else if (wr_at(`IDX_CTRL)) begin
            ctrl <= ccu_pkg::ctrl_t'(pwdata[7:0]);
        end else if (wr_at(`IDX_CC_FUNC)) begin
            cc_func <= pwdata[7:0];
        end else if (wr_at(`IDX_CC_MODE)) begin
            cc_mode <= pwdata[7:0];
        end else if (wr_at(`IDX_CC_EDGE)) begin
            cc_edge <= pwdata[3:0];
        end else if (wr_at(`IDX_CM_EN)) begin
            cm_en <= pwdata[7:0];
        end else if (wr_at(`IDX_CM_SEL)) begin
            cm_sel <= pwdata[7:0];
        end else if (wr_at(`IDX_CM_LEVEL)) begin
            cm_level <= pwdata[7:0];
        end else if (wr_at(`IDX_CT_PRE)) begin
            ct_pre <= pwdata[7:0];
        end else if (wr_at(`IDX_SET_MASK)) begin
            set_mask <= pwdata[7:0];
        end else if (wr_at(`IDX_CLR_MASK)) begin
            clear_mask <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // general timer with reload
    // ----------------------------------------------------------------
    assign base_tick = ctrl.gt_run && gt_div == `GT_BASE_DIV;
    assign gt_tick = base_tick && gt_pre == ctrl.gt_presc;
    assign gt_ovf = gt_tick && gt == `COUNT_TOP;
    assign gt_next = gt + 16'h0001;
    assign crc = cc_val[0];
    assign pin_reload = ctrl.reload_mode == ccu_pkg::RL_PIN
        && ext_prev && !external_reload_pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gt_div <= 4'h0;
            gt_pre <= 2'h0;
        end else if (!ctrl.gt_run || base_tick) begin
            gt_div <= 4'h0;
            gt_pre <= (gt_tick || !ctrl.gt_run) ? 2'h0 : gt_pre + 2'h1;
        end else begin
            gt_div <= gt_div + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gt <= `RESET_WORD;
        end else if (wr_at(`IDX_GT_LO)) begin
            gt[7:0] <= pwdata[7:0];
        end else if (wr_at(`IDX_GT_HI)) begin
            gt[15:8] <= pwdata[7:0];
        end else if (pin_reload) begin
            gt <= crc;
        end else if (gt_ovf) begin
            gt <= (ctrl.reload_mode == ccu_pkg::RL_OVF) ? crc
                : `RESET_WORD;
        end else if (gt_tick) begin
            gt <= gt_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev <= 1'b1;
            cc_prev <= 4'h0;
        end else begin
            ext_prev <= external_reload_pin;
            cc_prev <= cc_pin_in;
        end
    end

    // ----------------------------------------------------------------
    // compare timer
    // ----------------------------------------------------------------
    // the divider never runs below two clocks per count
    assign ct_tick = ctrl.ct_run && ct_div == {ct_pre, 1'b1};
    assign ct_ovf = ct_tick && ct == `COUNT_TOP;
    assign ct_next = ct + 16'h0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ct_div <= 9'h000;
            ct <= `RESET_WORD;
            ct_reload <= `RESET_WORD;
        end else begin
            ct_div <= (!ctrl.ct_run || ct_tick) ? 9'h000 : ct_div + 9'h001;
            if (ct_ovf) begin
                ct <= ct_reload;
            end else if (ct_tick) begin
                ct <= ct_next;
            end
            if (wr_at(`IDX_CT_RELOAD_LO)) begin
                ct_reload[7:0] <= pwdata[7:0];
            end else if (wr_at(`IDX_CT_RELOAD_HI)) begin
                ct_reload[15:8] <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // compare/capture channels on the general timer
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_cc
        logic [1:0] func;
        logic edge_ev;
        assign func = cc_func[2 * i +: 2];
        assign edge_ev = cc_edge[i] ? (!cc_prev[i] && cc_pin_in[i])
            : (cc_prev[i] && !cc_pin_in[i]);
        assign cc_hit[i] = func == ccu_pkg::CC_COMPARE
            && gt_hit(gt_tick, gt_next, cc_val[i]);
        assign flag_set.cc_event[i] = cc_hit[i] || edge_ev;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cc_val[i] <= `RESET_WORD;
            end else if (wr_at(cc_lo(i))) begin
                cc_val[i][7:0] <= pwdata[7:0];
                if (func == ccu_pkg::CC_CAP_SW) begin
                    cc_val[i] <= gt;
                end
            end else if (wr_at(cc_lo(i) + 10'h001)) begin
                cc_val[i][15:8] <= pwdata[7:0];
            end else if (func == ccu_pkg::CC_CAP_PIN && edge_ev) begin
                cc_val[i] <= gt;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cc_out[i] <= 1'b0;
            end else if (!cc_mode[i]) begin
                // a match on the overflow edge itself wins
                if (cc_hit[i]) begin
                    cc_out[i] <= 1'b1;
                end else if (gt_ovf) begin
                    cc_out[i] <= 1'b0;
                end
            end else if (cc_hit[i]) begin
                cc_out[i] <= cc_mode[4 + i];
            end
        end
    end

    // ----------------------------------------------------------------
    // general compare channels, either timer
    // ----------------------------------------------------------------
    for (genvar j = 0; j < 8; j++) begin : g_cm
        logic on_ct, ovf, hit;
        assign on_ct = cm_sel[j];
        assign ovf = on_ct ? ct_ovf : gt_ovf;
        // shadows keep a late write from skipping a match this period
        assign hit = cm_en[j] && (on_ct
            ? (ct_tick && ct_next == cm_shadow[j])
            : gt_hit(gt_tick, gt_next, cm_val[j]));
        assign cm_hit_gt[j] = hit && !on_ct;
        assign flag_set.cm_match[j] = cm_hit_gt[j];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cm_val[j] <= `RESET_WORD;
                cm_shadow[j] <= `RESET_WORD;
            end else begin
                if (wr_at(cm_lo(j))) begin
                    cm_val[j][7:0] <= pwdata[7:0];
                end else if (wr_at(cm_lo(j) + 10'h001)) begin
                    cm_val[j][15:8] <= pwdata[7:0];
                end
                if (ovf) begin
                    cm_shadow[j] <= cm_val[j];
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cm_out[j] <= 1'b0;
            end else if (on_ct) begin
                if (hit) begin
                    cm_out[j] <= 1'b1;
                end else if (ovf) begin
                    cm_out[j] <= 1'b0;
                end
            end else if (hit) begin
                cm_out[j] <= cm_level[j];
            end
        end
    end

    // ----------------------------------------------------------------
    // mode 2 set/clear compare on port 5
    // ----------------------------------------------------------------
    assign set_hit = ctrl.mode2_en && gt_hit(gt_tick, gt_next, comset);
    assign clr_hit = ctrl.mode2_en && gt_hit(gt_tick, gt_next, comclr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comset <= `RESET_WORD;
            comclr <= `RESET_WORD;
        end else if (wr_at(`IDX_COMSET_LO)) begin
            comset[7:0] <= pwdata[7:0];
        end else if (wr_at(`IDX_COMSET_HI)) begin
            comset[15:8] <= pwdata[7:0];
        end else if (wr_at(`IDX_COMCLR_LO)) begin
            comclr[7:0] <= pwdata[7:0];
        end else if (wr_at(`IDX_COMCLR_HI)) begin
            comclr[15:8] <= pwdata[7:0];
        end
    end

    // a hardware match overrides a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifth_port_register <= `RESET_PORT;
        end else begin
            fifth_port_register <= ((wr_at(`IDX_PORT5) ? pwdata[7:0]
                : fifth_port_register) | (set_hit ? set_mask : 8'h00))
                & ~(clr_hit ? clear_mask : 8'h00);
        end
    end
    assign port5_out = fifth_port_register;

    // ----------------------------------------------------------------
    // request flags
    // ----------------------------------------------------------------
    assign flag_set.general_timer_overflow_flag = gt_ovf;
    assign flag_set.external_reload_flag = pin_reload;
    assign flag_set.compare_timer_overflow_flag = ct_ovf;
    assign flag_set.set_match_flag = set_hit;
    assign flag_set.clear_match_flag = clr_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= ccu_pkg::flags_t'(17'h00000);
        end else if (wr_at(`IDX_FLAGS)) begin
            flags <= (flags & ~pwdata[16:0]) | flag_set;
        end else begin
            flags <= flags | flag_set;
        end
    end

    assign irq_timer2 = flags.general_timer_overflow_flag
        || flags.external_reload_flag;
    assign irq_compare = |flags.cm_match;
    assign irq_set_match = flags.set_match_flag;
    assign irq_clear_match = flags.clear_match_flag;
    assign irq_compare_timer = flags.compare_timer_overflow_flag;
    assign irq_cc = flags.cc_event;

    // ----------------------------------------------------------------
    // apb read side
    // ----------------------------------------------------------------
    always_comb begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        if (widx == `IDX_CTRL) begin
            rd_data[7:0] = ctrl;
        end else if (widx == `IDX_CC_FUNC) begin
            rd_data[7:0] = cc_func;
        end else if (widx == `IDX_CC_MODE) begin
            rd_data[7:0] = cc_mode;
        end else if (widx == `IDX_CC_EDGE) begin
            rd_data[3:0] = cc_edge;
        end else if (widx == `IDX_CM_EN) begin
            rd_data[7:0] = cm_en;
        end else if (widx == `IDX_CM_SEL) begin
            rd_data[7:0] = cm_sel;
        end else if (widx == `IDX_CM_LEVEL) begin
            rd_data[7:0] = cm_level;
        end else if (widx == `IDX_CT_PRE) begin
            rd_data[7:0] = ct_pre;
        end else if (widx == `IDX_CT_RELOAD_LO) begin
            rd_data[7:0] = ct_reload[7:0];
        end else if (widx == `IDX_CT_RELOAD_HI) begin
            rd_data[7:0] = ct_reload[15:8];
        end else if (widx == `IDX_SET_MASK) begin
            rd_data[7:0] = set_mask;
        end else if (widx == `IDX_CLR_MASK) begin
            rd_data[7:0] = clear_mask;
        end else if (widx == `IDX_COMSET_LO) begin
            rd_data[7:0] = comset[7:0];
        end else if (widx == `IDX_COMSET_HI) begin
            rd_data[7:0] = comset[15:8];
        end else if (widx == `IDX_COMCLR_LO) begin
            rd_data[7:0] = comclr[7:0];
        end else if (widx == `IDX_COMCLR_HI) begin
            rd_data[7:0] = comclr[15:8];
        end else if (widx == `IDX_GT_LO) begin
            rd_data[7:0] = gt[7:0];
        end else if (widx == `IDX_GT_HI) begin
            rd_data[7:0] = gt[15:8];
        end else if (widx == `IDX_PORT5) begin
            rd_data[7:0] = port5_in;
        end else if (widx == `IDX_FLAGS) begin
            rd_data[16:0] = flags;
        end else begin
            rd_ok = 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            if (widx == cc_lo(i)) begin
                rd_data[7:0] = cc_val[i][7:0];
                rd_ok = 1'b1;
            end else if (widx == cc_lo(i) + 10'h001) begin
                rd_data[7:0] = cc_val[i][15:8];
                rd_ok = 1'b1;
            end
        end
        for (int j = 0; j < 8; j++) begin
            if (widx == cm_lo(j)) begin
                rd_data[7:0] = cm_val[j][7:0];
                rd_ok = 1'b1;
            end else if (widx == cm_lo(j) + 10'h001) begin
                rd_data[7:0] = cm_val[j][15:8];
                rd_ok = 1'b1;
            end
        end
    end

    // sampled in the setup cycle, so the access cycle never waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : rd_data;
            pslverr <= !rd_ok;
        end
    end
    assign pready = 1'b1;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence pin_fall_s;
        ctrl.reload_mode == ccu_pkg::RL_PIN && ext_prev
            && !external_reload_pin;
    endsequence
    sequence no_gt_write_s;
        !wr_at(`IDX_GT_LO) && !wr_at(`IDX_GT_HI);
    endsequence

    pin_reload_val_a: assert property (pin_fall_s and no_gt_write_s
        |=> gt == $past(crc)) else $error("pin reload value wrong");
    pin_reload_flag_a: assert property (pin_fall_s
        |=> flags.external_reload_flag) else $error("reload flag missing");
    auto_reload_a: assert property ((gt_ovf && !pin_reload
        && ctrl.reload_mode == ccu_pkg::RL_OVF) and no_gt_write_s
        |=> gt == $past(crc)) else $error("auto reload wrong");
    gt_tick_gap_a: assert property (gt_tick |=> (!gt_tick) [*8])
        else $error("general timer ticks too fast");
    set_mask_high_a: assert property (set_hit && !clr_hit
        |=> (port5_out & $past(set_mask)) == $past(set_mask))
        else $error("set mask pins not high");
    clr_mask_low_a: assert property (clr_hit
        |=> (port5_out & $past(clear_mask)) == 8'h00)
        else $error("clear mask pins not low");
    set_flag_hold_a: assert property (flags.set_match_flag
        && !(wr_at(`IDX_FLAGS) && pwdata[3]) |=> flags.set_match_flag)
        else $error("flag dropped without clear");
    sw_capture_a: assert property (wr_at(cc_lo(1))
        && cc_func[3:2] == ccu_pkg::CC_CAP_SW |=> cc_val[1] == $past(gt))
        else $error("software capture wrong");
    mode0_ovf_low_a: assert property (!cc_mode[0] && gt_ovf
        && !cc_hit[0] |=> !cc_out[0]) else $error("mode 0 not low");
    shadow_load_a: assert property (cm_sel[0] && ct_ovf
        |=> cm_shadow[0] == $past(cm_val[0])) else $error("shadow not loaded");
    ct_half_clock_a: assert property (ct_tick |=> !ct_tick)
        else $error("compare timer too fast");
endmodule : compare_capture_reload_unit

// File: testbench/pin_model.sv
// external pin model for port 5 and the capture and reload inputs
`timescale 1ns/10ps
module pin_model (
    input wire logic pclk,
    input wire logic [7:0] port5_out,
    input wire logic [3:0] cc_drive,
    input wire logic rl_drive,
    output logic [7:0] port5_in,
    output logic [3:0] cc_pin_in = 4'h0,
    output logic external_reload_pin = 1'b1
);
    // bit 7 is held low outside, so a read shows the pin, not the latch
    assign port5_in = port5_out & 8'h7F;
    // outside pins lag the request by one edge, like a real source
    always @(posedge pclk) begin
        cc_pin_in <= cc_drive;
        external_reload_pin <= rl_drive;
    end
endmodule : pin_model

// File: testbench/test_compare_capture_reload_unit.sv
// self-checking bench of the compare, capture and reload unit
`timescale 1ns/10ps
`include "ccu_map.svh"
module test_compare_capture_reload_unit;
logic pclk = 1'b0;
logic presetn = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h0;
logic [31:0] pwdata = 32'h0;
logic [31:0] prdata, got;
logic pready, pslverr, irq_timer2, irq_set_match, irq_clear_match;
logic irq_compare, irq_compare_timer;
logic [3:0] cc_pin_in, irq_cc, cc_out;
logic [3:0] cc_drive = 4'h0;
logic rl_drive = 1'b1;
logic external_reload_pin;
logic [7:0] port5_in, port5_out, cm_out, m, k, r;
logic [31:0] lf = 32'hBCF1;
int n_mismatch = 0;
int total_checks = 0;
int cyc = 0;
compare_capture_reload_unit dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cc_pin_in,
    .cc_out, .cm_out, .port5_in, .port5_out, .external_reload_pin,
    .irq_timer2, .irq_compare, .irq_set_match, .irq_clear_match,
    .irq_compare_timer, .irq_cc);
pin_model pins_u (.pclk, .port5_out, .cc_drive, .rl_drive, .port5_in,
    .cc_pin_in, .external_reload_pin);
// ----------------------------------------
// helpers
// ----------------------------------------
function automatic logic [7:0] p5_exp(input logic [7:0] a, s, c);
    return (a | s) & ~c;
endfunction : p5_exp
function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction : lfsr
task automatic chk(input string nm, input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
        n_mismatch++;
        $display("[ERR] %s exp %h got %h", nm, e, g);
    end
endtask : chk
task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    got = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
endtask : xfer
task automatic wr(input logic [9:0] i, input logic [31:0] d);
    xfer(1'b1, i, d);
endtask : wr
task automatic rd(input logic [9:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0);
    chk($sformatf("reg %h", i), got, e);
endtask : rd
task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
endtask : report_and_stop
// ----------------------------------------
// clock, timeout and main sequence
// ----------------------------------------
initial begin
    forever #2 pclk = ~pclk;
end
always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
        n_mismatch++;
        report_and_stop();
    end
end
initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`IDX_SET_MASK, 32'h0);
    rd(`IDX_PORT5, 32'h7F);
    xfer(1'b0, 10'h3FF, 32'h0);
    chk("pslverr", pslverr, 32'h1);
    lf = lfsr(lf);
    {r, k, m} = lf[23:0];
    wr(`IDX_SET_MASK, m);
    wr(`IDX_CLR_MASK, k);
    wr(`IDX_PORT5, r);
    rd(`IDX_CLR_MASK, k);
    rd(`IDX_PORT5, r & 8'h7F);
    wr(`IDX_COMSET_HI, 32'h0);
    wr(`IDX_COMSET_LO, 32'h10);
    wr(`IDX_COMCLR_HI, 32'h0);
    wr(`IDX_COMCLR_LO, 32'h20);
    wr(`IDX_GT_HI, 32'h0);
    wr(`IDX_GT_LO, 32'h0E);
    wr(`IDX_CTRL, 32'h44);
    // two ticks of twelve clocks reach the set value, plus slack
    repeat (60) @(posedge pclk);
    chk("port5_out", port5_out, p5_exp(r, m, 8'h0));
    chk("irq_set_match", irq_set_match, 32'h1);
    chk("irq_clear_match", irq_clear_match, 32'h0);
    wr(`IDX_FLAGS, 32'h8);
    repeat (250) @(posedge pclk);
    chk("port5_out", port5_out, p5_exp(r, m, k));
    chk("irq_clear_match", irq_clear_match, 32'h1);
    chk("irq_set_match", irq_set_match, 32'h0);
    wr(`IDX_CTRL, 32'h0);
    wr(`IDX_CC_FUNC, 32'h1C);
    wr(`IDX_CC_EDGE, 32'h4);
    lf = lfsr(lf);
    wr(`IDX_GT_HI, lf[15:8]);
    wr(`IDX_GT_LO, lf[7:0]);
    wr(`IDX_CC_BASE + 10'h2, 32'h0);
    rd(`IDX_CC_BASE + 10'h2, lf[7:0]);
    rd(`IDX_CC_BASE + 10'h3, lf[15:8]);
    cc_drive <= 4'h4;
    repeat (5) @(posedge pclk);
    rd(`IDX_CC_BASE + 10'h4, lf[7:0]);
    rd(`IDX_CC_BASE + 10'h5, lf[15:8]);
    chk("irq_cc", irq_cc, 32'h4);
    wr(`IDX_CRC_HI, lf[31:24]);
    wr(`IDX_CRC_LO, lf[23:16]);
    wr(`IDX_CTRL, 32'h18);
    rl_drive <= 1'b0;
    repeat (4) @(posedge pclk);
    rl_drive <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`IDX_GT_LO, lf[23:16]);
    rd(`IDX_GT_HI, lf[31:24]);
    chk("irq_timer2", irq_timer2, 32'h1);
    wr(`IDX_GT_HI, 32'h0);
    wr(`IDX_GT_LO, 32'h0);
    wr(`IDX_CC_FUNC, 32'h80);
    wr(`IDX_CC_BASE + 10'h7, 32'h0);
    wr(`IDX_CC_BASE + 10'h6, 32'h2);
    wr(`IDX_CM_BASE + 10'h1, 32'h0);
    wr(`IDX_CM_BASE, 32'h2);
    wr(`IDX_CM_LEVEL, 32'h1);
    wr(`IDX_CM_EN, 32'h1);
    wr(`IDX_CTRL, 32'h4);
    repeat (30) @(posedge pclk);
    chk("cc_out", cc_out, 32'h8);
    chk("cm_out", cm_out, 32'h1);
    chk("irq_compare", irq_compare, 32'h1);
    chk("irq_cc", irq_cc, 32'hC);
    wr(`IDX_CTRL, 32'h0);
    wr(`IDX_GT_HI, 32'hFF);
    wr(`IDX_GT_LO, 32'hFE);
    wr(`IDX_CTRL, 32'h14);
    repeat (30) @(posedge pclk);
    chk("cc_out", cc_out, 32'h0);
    chk("cm_out", cm_out, 32'h1);
    chk("irq_compare_timer", irq_compare_timer, 32'h0);
    rd(`IDX_GT_LO, lf[23:16]);
    report_and_stop();
end
endmodule : test_compare_capture_reload_unit
